// >>> hw/hppc_pkg.sv
// Package for hub port power and status change logic
`default_nettype none
package hppc_pkg;
    // Port and gang dimensions (defaults)
    localparam int NUM_PORTS = 7;
    localparam int NUM_PGANGS = 2;
    localparam int NUM_OCGANGS = 3;
    // Request codes on the feature port
    localparam logic [2:0] REQ_NONE = 3'h0;
    localparam logic [2:0] REQ_SET_POWER = 3'h1;
    localparam logic [2:0] REQ_CLR_POWER = 3'h2;
    localparam logic [2:0] REQ_CLR_C_OC = 3'h3;
    localparam logic [2:0] REQ_CLR_C_CONN = 3'h4;
    localparam logic [2:0] REQ_CLR_C_HUB_LP = 3'h5;
    localparam logic [2:0] REQ_CLR_C_HUB_OC = 3'h6;
    // Logical power switching mode encodings
    localparam logic [1:0] PSW_GANGED = 2'h0;
    localparam logic [1:0] PSW_PERPORT = 2'h1;
    // Over-current reporting mode encodings
    localparam logic [1:0] OCR_GLOBAL = 2'h0;
    localparam logic [1:0] OCR_PERPORT = 2'h1;
    // Power-on to power-good for switchless hubs
    localparam logic [7:0] PWRGOOD_NONE = 8'h00;
    // Poll answer states
    typedef enum logic [2:0] {
        HPPC_IDLE = 3'b001,
        HPPC_DATA = 3'b010,
        HPPC_NAK = 3'b100
    } hppc_poll_t;
endpackage
`default_nettype wire

// >>> hw/hppc_top.sv
// Hub port power switching, over-current and status change bitmap
// Operation
// - per-port switching powers the addressed port
// - ganged switching turns on the addressed port's gang switch
// - gang power off when members off/unconfigured
// - ignore power-on while local power lost
// - powered-off state; power mask all ones
// - no switches means zero power-good delay
// - multi-gang hubs advertise per-port modes
// - over-current forces protected ports powered-off
// - live status; change cleared per port
// - shared switch leaves other ports off
// - open switches tied to signalling circuit
// - over-current and power gangs tracked apart
// - poll with no changes answers NAK
// - change flags sticky until cleared/reset
// - bit zero hub, higher bits ports
// - whole bytes, absent ports read zero
// - dragged port gets change, no status
// - hub-wide over-current sets no port flags
// - status live, change marks transitions
// - switching mode field always implemented
// - descriptor and status always readable
// - reset clears changes, ports unconfigured
`default_nettype none
module hppc_top
    import hppc_pkg::*;
#(
    parameter int NPORT = NUM_PORTS,
    parameter int NPG = NUM_PGANGS,
    parameter int NOCG = NUM_OCGANGS,
    parameter bit HAS_SWITCHES = 1'b1,
    parameter bit HUB_WIDE_OC = 1'b0,
    parameter logic [7:0] PWRON2GOOD = 8'h32,
    parameter logic [NPORT*8-1:0] PORT_PGANG = '0,
    parameter logic [NPORT*8-1:0] PORT_OCGANG = '0,
    parameter int NBYTES = (NPORT + 8) / 8
)
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic CONFIGURED,
    input wire logic [2:0] REQ_CODE,
    input wire logic [7:0] REQ_PORT,
    input wire logic REQ_VALID,
    input wire logic [NOCG-1:0] OC_PIN,
    input wire logic HUB_OC_PIN,
    input wire logic LOCAL_PWR_LOST_PIN,
    input wire logic [NPORT-1:0] PORT_DRAGGED_PIN,
    input wire logic [NPORT-1:0] CONNECT_PIN,
    input wire logic POLL,
    output logic [NPG-1:0] GANG_PWR_EN,
    output logic [NPORT-1:0] PORT_POWERED,
    output logic [NPORT-1:0] PORT_OC_STATUS,
    output logic [NPORT-1:0] PORT_C_OC,
    output logic [NPORT-1:0] PORT_C_CONN,
    output logic HUB_LP_STATUS,
    output logic HUB_C_LP,
    output logic HUB_OC_STATUS,
    output logic HUB_C_OC,
    output logic [NBYTES*8-1:0] POLL_BITMAP,
    output logic POLL_DATA,
    output logic POLL_NAK,
    output logic [1:0] PSW_MODE,
    output logic [1:0] OCR_MODE,
    output logic [7:0] PWR_GOOD_DELAY,
    output logic [NPORT-1:0] PWR_CTRL_MASK
);

    localparam int NSYNC = NOCG + 2 + 2 * NPORT;

    logic [NSYNC-1:0] sync1;
    logic [NSYNC-1:0] sync2;
    logic [NSYNC-1:0] sync3;
    logic [NSYNC-1:0] stable;
    logic [NSYNC-1:0] next_stable;
    logic [NPORT-1:0] powered;
    logic [NPORT-1:0] next_powered;
    logic [NPORT-1:0] oc_c;
    logic [NPORT-1:0] conn_c;
    logic lp_c;
    logic hoc_c;
    logic [NPG-1:0] gang_on;
    logic [NPG-1:0] next_gang_on;
    logic [NBYTES*8-1:0] bitmap;
    hppc_poll_t poll_st;
    hppc_poll_t next_poll_st;

    wire [NOCG-1:0] oc_s = stable[NOCG-1:0];
    wire hub_oc_s = stable[NOCG];
    wire lp_lost_s = stable[NOCG+1];
    wire [NPORT-1:0] drag_s = stable[NOCG+2 +: NPORT];
    wire [NPORT-1:0] conn_s = stable[NOCG+2+NPORT +: NPORT];
    wire [NSYNC-1:0] raw_in = {CONNECT_PIN, PORT_DRAGGED_PIN, LOCAL_PWR_LOST_PIN,
                               HUB_OC_PIN, OC_PIN};
    // Accept a change once stages two and three agree
    wire [NSYNC-1:0] agree = ~(sync2 ^ sync3);
    wire [NSYNC-1:0] rise = next_stable & ~stable;
    wire [NSYNC-1:0] edge_any = next_stable ^ stable;
    wire [NOCG-1:0] oc_rise = rise[NOCG-1:0];
    wire hub_oc_edge = edge_any[NOCG];
    wire lp_edge = edge_any[NOCG+1];
    wire [NPORT-1:0] drag_rise = rise[NOCG+2 +: NPORT];
    wire [NPORT-1:0] conn_edge = edge_any[NOCG+2+NPORT +: NPORT];
    wire req_hit = REQ_VALID && (REQ_PORT != 8'h00) && (REQ_PORT <= 8'(NPORT));
    wire [7:0] req_idx = REQ_PORT - 8'h01;
    wire hub_req = REQ_VALID && (REQ_PORT == 8'h00);
    // Local power lost blocks power-on requests only while its change flag is also set
    // power-on suppression check
    wire lp_block = lp_c && lp_lost_s;
    wire any_change = |bitmap;

    // Per-port decode of requests and over-current effects
    logic [NPORT-1:0] port_sel;
    logic [NPORT-1:0] set_pwr;
    logic [NPORT-1:0] oc_hit;
    logic [NPORT-1:0] oc_live;
    logic [NPORT-1:0] oc_new;
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++)
        begin : g_port
            localparam int OCG = int'(PORT_OCGANG[gi*8 +: 8]) % NOCG;
            assign port_sel[gi] = req_hit && (req_idx == 8'(gi));
            assign set_pwr[gi] = port_sel[gi] && (REQ_CODE == REQ_SET_POWER) && !lp_block
                                 && CONFIGURED;
            assign oc_live[gi] = HUB_WIDE_OC ? 1'b0 : oc_s[OCG];
            assign oc_new[gi] = HUB_WIDE_OC ? 1'b0 : oc_rise[OCG];
            assign oc_hit[gi] = HUB_WIDE_OC ? hub_oc_s : oc_s[OCG];
        end
    endgenerate

    // Power state of each port
    always_comb
    begin
        next_powered = powered;
        for (int i = 0; i < NPORT; i++)
        begin
            if (set_pwr[i])
                next_powered[i] = 1'b1;
            if (port_sel[i] && REQ_CODE == REQ_CLR_POWER)
                next_powered[i] = 1'b0;
            if (oc_hit[i] || drag_s[i] || lp_lost_s || !CONFIGURED)
                next_powered[i] = 1'b0;
        end
    end

    // Gang switch state from member requests and member states
    always_comb
    begin
        logic any_on;
        any_on = 1'b0;
        next_gang_on = gang_on;
        for (int g = 0; g < NPG; g++)
        begin
            for (int i = 0; i < NPORT; i++)
            begin
                if (set_pwr[i] && (int'(PORT_PGANG[i*8 +: 8]) % NPG) == g)
                    next_gang_on[g] = 1'b1;
                if (oc_hit[i] && (int'(PORT_PGANG[i*8 +: 8]) % NPG) == g)
                    next_gang_on[g] = 1'b0;
            end
        end
        // gang off when no member powered
        for (int g = 0; g < NPG; g++)
        begin
            any_on = 1'b0;
            for (int i = 0; i < NPORT; i++)
                if ((int'(PORT_PGANG[i*8 +: 8]) % NPG) == g)
                    any_on = any_on | next_powered[i];
            if (!any_on || !CONFIGURED)
                next_gang_on[g] = 1'b0;
        end
    end

    // Three-stage input synchroniser
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end
        else
        begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    assign next_stable = (agree & sync3) | (~agree & stable);

    // Power and sticky change flags
    // reset clears changes and power
    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            stable <= '0;
            powered <= '0;
            gang_on <= '0;
            oc_c <= '0;
            conn_c <= '0;
            lp_c <= 1'b0;
            hoc_c <= 1'b0;
        end
        else
        begin
            stable <= next_stable;
            powered <= next_powered;
            gang_on <= next_gang_on;
            for (int i = 0; i < NPORT; i++)
            begin
                if (oc_new[i] || drag_rise[i])
                    oc_c[i] <= 1'b1;
                else if (port_sel[i] && REQ_CODE == REQ_CLR_C_OC)
                    oc_c[i] <= 1'b0;
                if (conn_edge[i])
                    conn_c[i] <= 1'b1;
                else if (port_sel[i] && REQ_CODE == REQ_CLR_C_CONN)
                    conn_c[i] <= 1'b0;
            end
            if (lp_edge)
                lp_c <= 1'b1;
            else if (hub_req && REQ_CODE == REQ_CLR_C_HUB_LP)
                lp_c <= 1'b0;
            if (hub_oc_edge && HUB_WIDE_OC)
                hoc_c <= 1'b1;
            else if (hub_req && REQ_CODE == REQ_CLR_C_HUB_OC)
                hoc_c <= 1'b0;
        end
    end

    // Change bitmap: hub at bit zero, ports above, rest zero
    // bit layout
    always_comb
    begin
        bitmap = '0;
        bitmap[0] = lp_c | hoc_c;
        for (int i = 0; i < NPORT; i++)
            bitmap[i+1] = oc_c[i] | conn_c[i];
    end

    // Poll answer: data while any flag set, else NAK
    // NAK without changes
    always_comb
    begin
        case (poll_st)
            HPPC_IDLE: next_poll_st = POLL ? (any_change ? HPPC_DATA : HPPC_NAK) : HPPC_IDLE;
            HPPC_DATA: next_poll_st = HPPC_IDLE;
            HPPC_NAK: next_poll_st = HPPC_IDLE;
            default: next_poll_st = HPPC_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            poll_st <= HPPC_IDLE;
            POLL_BITMAP <= '0;
        end
        else
        begin
            poll_st <= next_poll_st;
            if (POLL && poll_st == HPPC_IDLE)
                POLL_BITMAP <= any_change ? bitmap : '0;
        end
    end

    assign POLL_DATA = (poll_st == HPPC_DATA);
    assign POLL_NAK = (poll_st == HPPC_NAK);

    // Status outputs; port status zero while local power lost
    // live over-current status
    assign PORT_OC_STATUS = lp_lost_s ? '0 : oc_live;
    assign PORT_C_OC = oc_c;
    assign PORT_C_CONN = conn_c;
    assign PORT_POWERED = powered;
    assign GANG_PWR_EN = HAS_SWITCHES ? gang_on : '1;
    assign HUB_LP_STATUS = lp_lost_s;
    assign HUB_C_LP = lp_c;
    assign HUB_OC_STATUS = HUB_WIDE_OC ? hub_oc_s : 1'b0;
    assign HUB_C_OC = hoc_c;

    // Descriptor fields
    // mask all ones
    assign PWR_CTRL_MASK = '1;
    assign PWR_GOOD_DELAY = HAS_SWITCHES ? PWRON2GOOD : PWRGOOD_NONE;
    assign PSW_MODE = (NPG > 1 || NOCG > 1 || !HAS_SWITCHES && !HUB_WIDE_OC
                       || NPG == NPORT) ? PSW_PERPORT : PSW_GANGED;
    assign OCR_MODE = (NPG > 1 || NOCG > 1 || !HUB_WIDE_OC) ? OCR_PERPORT : OCR_GLOBAL;

    // Assertions
    // check suppression
    a_lp_block_power: assert property (@(posedge CLK) disable iff (!RESETN)
        (lp_block && REQ_VALID && REQ_CODE == REQ_SET_POWER) |=> $stable(gang_on) || !(|gang_on))
        else $error("power-on not ignored during local power loss");
    a_oc_forces_off: assert property (@(posedge CLK) disable iff (!RESETN)
        (|(oc_hit)) |=> ((powered & oc_hit) == '0) || !$stable(oc_hit))
        else $error("over-current port still powered");
    a_oc_change_sticky: assert property (@(posedge CLK) disable iff (!RESETN)
        (|oc_new) |=> (PORT_C_OC & $past(oc_new)) == $past(oc_new))
        else $error("over-current change not set");
    a_nak_no_change: assert property (@(posedge CLK) disable iff (!RESETN)
        (POLL && poll_st == HPPC_IDLE && !any_change) |=> POLL_NAK && !POLL_DATA)
        else $error("poll without change not NAKed");
    a_data_on_change: assert property (@(posedge CLK) disable iff (!RESETN)
        (POLL && poll_st == HPPC_IDLE && any_change) |=> POLL_DATA ##1 !POLL_DATA)
        else $error("poll with change returned no data");
    a_pad_bits_zero: assert property (@(posedge CLK) disable iff (!RESETN)
        (POLL_BITMAP >> (NPORT + 1)) == '0)
        else $error("absent port bit set");
    a_unconf_gang_off: assert property (@(posedge CLK) disable iff (!RESETN)
        !CONFIGURED |=> gang_on == '0)
        else $error("gang powered while unconfigured");
    a_hub_oc_no_port: assert property (@(posedge CLK) disable iff (!RESETN)
        (HUB_WIDE_OC && hub_oc_s) |=> powered == '0 && PORT_OC_STATUS == '0)
        else $error("port left on or flagged under hub-wide over-current");
    c_poll_data: cover property (@(posedge CLK) disable iff (!RESETN) POLL_DATA);
    c_poll_nak: cover property (@(posedge CLK) disable iff (!RESETN) POLL_NAK);
    c_oc_event: cover property (@(posedge CLK) disable iff (!RESETN) |oc_new);
    c_gang_on: cover property (@(posedge CLK) disable iff (!RESETN) |gang_on);

endmodule // hppc_top
`default_nettype wire

// >>> testbench/hppc_host.sv
// Host model that sends hub requests and polls the change endpoint
`default_nettype none
module hppc_host
    import hppc_pkg::*;
(
    input wire logic clk,
    output logic [2:0] req_code,
    output logic [7:0] req_port,
    output logic req_valid,
    output logic poll,
    input wire logic poll_data,
    input wire logic poll_nak
);
    timeunit 1ns;
    timeprecision 100ps;

    // Idle bus at time zero
    initial
    begin
        req_code = REQ_NONE;
        req_port = 8'h00;
        req_valid = 1'b0;
        poll = 1'b0;
    end

    // One-cycle request strobe, fields scrambled once taken
    task automatic request(input logic [2:0] code, input logic [7:0] port);
        @(posedge clk);
        req_code <= code;
        req_port <= port;
        req_valid <= 1'b1;
        @(posedge clk);
        req_valid <= 1'b0;
        req_code <= ~code;
        req_port <= ~port;
        @(posedge clk);
        #1;
    endtask

    // Poll pulse, answer taken in the cycle after, one idle cycle
    task automatic poll_ep(output logic got_data, output logic got_nak);
        @(posedge clk);
        poll <= 1'b1;
        @(posedge clk);
        poll <= 1'b0;
        #1;
        got_data = poll_data;
        got_nak = poll_nak;
        @(posedge clk);
        #1;
    endtask
endmodule // hppc_host
`default_nettype wire

// >>> testbench/hppc_top_tb.sv
// Self-checking bench for hub port power and change logic
`default_nettype none
module hppc_top_tb
    import hppc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int NP = 7;
    localparam logic [7:0] P2G = 8'h14;
    localparam logic [NP*8-1:0] PG = {8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [NP*8-1:0] OG = {8'h02, 8'h02, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00};
    logic CLK = 1'b0, RESETN, CONFIGURED, HUB_OC_PIN, LOCAL_PWR_LOST_PIN;
    logic [2:0] REQ_CODE, OC_PIN;
    logic [7:0] REQ_PORT, POLL_BITMAP, PWR_GOOD_DELAY;
    logic REQ_VALID, POLL, POLL_DATA, POLL_NAK, HUB_LP_STATUS, HUB_C_LP, HUB_OC_STATUS, HUB_C_OC;
    logic [NP-1:0] PORT_DRAGGED_PIN, CONNECT_PIN, PORT_POWERED, PORT_OC_STATUS;
    logic [NP-1:0] PORT_C_OC, PORT_C_CONN, PWR_CTRL_MASK;
    logic [1:0] GANG_PWR_EN, PSW_MODE, OCR_MODE;
    logic H_HUB_OC, H_C_HUB_OC, H_GANG;
    logic [NP-1:0] H_POWERED, H_OC_STATUS, H_C_OC;
    logic [1:0] H_PSW, H_OCR;
    logic [7:0] H_DELAY;
    int n_errors = 0, n_checks = 0;

    // Clock at 200 MHz
    always #2.5 CLK = ~CLK;

    hppc_top #(.NPORT(NP), .NPG(2), .NOCG(3), .HAS_SWITCHES(1'b1), .HUB_WIDE_OC(1'b0),
        .PWRON2GOOD(P2G), .PORT_PGANG(PG), .PORT_OCGANG(OG)) hppc_top_i (
        .CLK(CLK), .RESETN(RESETN), .CONFIGURED(CONFIGURED), .REQ_CODE(REQ_CODE),
        .REQ_PORT(REQ_PORT), .REQ_VALID(REQ_VALID), .OC_PIN(OC_PIN), .HUB_OC_PIN(HUB_OC_PIN),
        .LOCAL_PWR_LOST_PIN(LOCAL_PWR_LOST_PIN), .PORT_DRAGGED_PIN(PORT_DRAGGED_PIN),
        .CONNECT_PIN(CONNECT_PIN), .POLL(POLL), .GANG_PWR_EN(GANG_PWR_EN),
        .PORT_POWERED(PORT_POWERED), .PORT_OC_STATUS(PORT_OC_STATUS), .PORT_C_OC(PORT_C_OC),
        .PORT_C_CONN(PORT_C_CONN), .HUB_LP_STATUS(HUB_LP_STATUS), .HUB_C_LP(HUB_C_LP),
        .HUB_OC_STATUS(HUB_OC_STATUS), .HUB_C_OC(HUB_C_OC), .POLL_BITMAP(POLL_BITMAP),
        .POLL_DATA(POLL_DATA), .POLL_NAK(POLL_NAK), .PSW_MODE(PSW_MODE), .OCR_MODE(OCR_MODE),
        .PWR_GOOD_DELAY(PWR_GOOD_DELAY), .PWR_CTRL_MASK(PWR_CTRL_MASK));

    // Switchless hub-wide variant on the same stimulus
    hppc_top #(.NPORT(NP), .NPG(1), .NOCG(1), .HAS_SWITCHES(1'b0), .HUB_WIDE_OC(1'b1),
        .PWRON2GOOD(P2G)) hppc_top_hw_i (
        .CLK(CLK), .RESETN(RESETN), .CONFIGURED(CONFIGURED), .REQ_CODE(REQ_CODE),
        .REQ_PORT(REQ_PORT), .REQ_VALID(REQ_VALID), .OC_PIN(OC_PIN[0]), .HUB_OC_PIN(HUB_OC_PIN),
        .LOCAL_PWR_LOST_PIN(LOCAL_PWR_LOST_PIN), .PORT_DRAGGED_PIN(PORT_DRAGGED_PIN),
        .CONNECT_PIN(CONNECT_PIN), .POLL(POLL), .GANG_PWR_EN(H_GANG),
        .PORT_POWERED(H_POWERED), .PORT_OC_STATUS(H_OC_STATUS), .PORT_C_OC(H_C_OC),
        .PORT_C_CONN(), .HUB_LP_STATUS(), .HUB_C_LP(),
        .HUB_OC_STATUS(H_HUB_OC), .HUB_C_OC(H_C_HUB_OC), .POLL_BITMAP(),
        .POLL_DATA(), .POLL_NAK(), .PSW_MODE(H_PSW), .OCR_MODE(H_OCR),
        .PWR_GOOD_DELAY(H_DELAY), .PWR_CTRL_MASK());

    hppc_host hppc_host_i (.clk(CLK), .req_code(REQ_CODE), .req_port(REQ_PORT),
        .req_valid(REQ_VALID), .poll(POLL), .poll_data(POLL_DATA), .poll_nak(POLL_NAK));

    // Ports of gang g in a gang map, bit i is port i+1
    function automatic logic [NP-1:0] members(input logic [NP*8-1:0] map, input int g);
        for (int i = 0; i < NP; i++) members[i] = (map[i*8 +: 8] == g);
    endfunction

    // Pseudo-random step
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic chk(input bit ok, input string what);
        n_checks++;
        if (!ok)
        begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #100000;
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        logic d, n;
        logic [7:0] seed;
        logic [NP-1:0] pat;
        int p;
        seed = 8'h13;
        {RESETN, HUB_OC_PIN, LOCAL_PWR_LOST_PIN, OC_PIN} = '0;
        {PORT_DRAGGED_PIN, CONNECT_PIN} = '0;
        CONFIGURED = 1'b1;
        repeat (20) @(posedge CLK);
        RESETN <= 1'b1;
        cyc(4);
        chk(PWR_CTRL_MASK === 7'h7f, "power mask");
        chk(PSW_MODE === PSW_PERPORT && OCR_MODE === OCR_PERPORT, "modes");
        chk(PWR_GOOD_DELAY === P2G, "delay field");
        chk(H_PSW === PSW_GANGED && H_OCR === OCR_GLOBAL, "switchless modes");
        chk(H_DELAY === PWRGOOD_NONE && H_GANG === 1'b1, "switchless delay");
        hppc_host_i.poll_ep(d, n);
        chk(n === 1'b1 && d === 1'b0, "nak when clean");
        for (int k = 0; k < 8; k++)
        begin
            seed = lfsr(seed);
            p = 1 + seed % NP;
            hppc_host_i.request(REQ_SET_POWER, 8'(p));
            chk(PORT_POWERED === 7'(1 << (p - 1)), "one port on");
            chk(GANG_PWR_EN === 2'(1 << PG[(p - 1)*8 +: 8]), "gang on");
            hppc_host_i.request(REQ_CLR_POWER, 8'(p));
            chk(GANG_PWR_EN === 2'h0 && PORT_POWERED === 7'h00, "gang off");
        end
        hppc_host_i.request(REQ_SET_POWER, 8'h01);
        hppc_host_i.request(REQ_SET_POWER, 8'h02);
        hppc_host_i.request(REQ_CLR_POWER, 8'h01);
        chk(GANG_PWR_EN === 2'h1 && PORT_POWERED === 7'h02, "gang held");
        hppc_host_i.request(REQ_SET_POWER, 8'h09);
        chk(PORT_POWERED === 7'h02, "bad port ignored");
        @(posedge CLK);
        CONFIGURED <= 1'b0;
        cyc(2);
        chk(GANG_PWR_EN === 2'h0, "unconfigured off");
        @(posedge CLK);
        CONFIGURED <= 1'b1;
        LOCAL_PWR_LOST_PIN <= 1'b1;
        cyc(6);
        chk(HUB_LP_STATUS === 1'b1 && HUB_C_LP === 1'b1, "local power");
        hppc_host_i.poll_ep(d, n);
        chk(d === 1'b1 && POLL_BITMAP === 8'h01, "hub bit");
        hppc_host_i.request(REQ_SET_POWER, 8'h01);
        chk(PORT_POWERED === 7'h00, "power-on ignored");
        @(posedge CLK);
        LOCAL_PWR_LOST_PIN <= 1'b0;
        cyc(6);
        hppc_host_i.request(REQ_SET_POWER, 8'h01);
        chk(PORT_POWERED === 7'h01, "power-on with change only");
        hppc_host_i.request(REQ_CLR_C_HUB_LP, 8'h00);
        chk(HUB_C_LP === 1'b0, "hub change cleared");
        hppc_host_i.request(REQ_SET_POWER, 8'h01);
        hppc_host_i.request(REQ_SET_POWER, 8'h03);
        chk(PORT_POWERED === 7'h05 && H_POWERED === 7'h05, "others stay off");
        @(posedge CLK);
        HUB_OC_PIN <= 1'b1;
        cyc(6);
        chk(H_POWERED === 7'h00 && H_C_OC === 7'h00 && H_OC_STATUS === 7'h00, "hub-wide");
        chk(H_HUB_OC === 1'b1 && H_C_HUB_OC === 1'b1, "hub oc change");
        chk(HUB_C_OC === 1'b0 && PORT_POWERED === 7'h05, "per-port hub ignores");
        @(posedge CLK);
        HUB_OC_PIN <= 1'b0;
        cyc(6);
        hppc_host_i.request(REQ_CLR_C_HUB_OC, 8'h00);
        chk(H_C_HUB_OC === 1'b0 && HUB_OC_STATUS === 1'b0, "hub oc cleared");
        @(posedge CLK);
        OC_PIN <= 3'h2;
        cyc(6);
        chk(PORT_OC_STATUS === members(OG, 1), "oc status");
        chk(PORT_C_OC === members(OG, 1) && PORT_POWERED[2] === 1'b0, "oc off");
        chk(GANG_PWR_EN === 2'h0, "switches opened");
        hppc_host_i.poll_ep(d, n);
        chk(d === 1'b1 && POLL_BITMAP === {members(OG, 1), 1'b0}, "port bits");
        @(posedge CLK);
        OC_PIN <= 3'h0;
        for (int w = 0; w < 20 && PORT_OC_STATUS !== 7'h00; w++) cyc(1);
        chk(PORT_OC_STATUS === 7'h00 && PORT_C_OC === members(OG, 1), "sticky");
        hppc_host_i.request(REQ_CLR_C_OC, 8'h03);
        chk(PORT_C_OC === 7'h18, "cleared per port");
        hppc_host_i.request(REQ_CLR_C_OC, 8'h04);
        hppc_host_i.request(REQ_CLR_C_OC, 8'h05);
        hppc_host_i.request(REQ_SET_POWER, 8'h03);
        chk(PORT_POWERED[2] === 1'b1 && PORT_C_OC === 7'h00, "repowered");
        hppc_host_i.poll_ep(d, n);
        chk(n === 1'b1, "nak after clears");
        hppc_host_i.request(REQ_SET_POWER, 8'h07);
        @(posedge CLK);
        PORT_DRAGGED_PIN <= 7'h40;
        cyc(6);
        chk(PORT_POWERED[6] === 1'b0 && PORT_C_OC[6] === 1'b1, "dragged off");
        chk(PORT_OC_STATUS[6] === 1'b0, "dragged no status");
        @(posedge CLK);
        PORT_DRAGGED_PIN <= 7'h00;
        hppc_host_i.request(REQ_CLR_C_OC, 8'h07);
        seed = lfsr(seed);
        pat = seed[6:0] | 7'h01;
        @(posedge CLK);
        CONNECT_PIN <= pat;
        cyc(6);
        chk(PORT_C_CONN === pat, "connect change");
        hppc_host_i.poll_ep(d, n);
        chk(POLL_BITMAP === {pat, 1'b0}, "connect bitmap");
        hppc_host_i.request(REQ_CLR_C_CONN, 8'h01);
        chk(PORT_C_CONN === (pat & 7'h7e), "connect cleared");
        @(posedge CLK);
        CONNECT_PIN <= 7'h00;
        cyc(6);
        @(posedge CLK);
        RESETN <= 1'b0;
        cyc(2);
        chk(PORT_C_CONN === 7'h00 && GANG_PWR_EN === 2'h0, "reset clears");
        @(posedge CLK);
        RESETN <= 1'b1;
        cyc(6);
        hppc_host_i.poll_ep(d, n);
        chk(n === 1'b1 && PORT_POWERED === 7'h00, "clean after reset");
        complete_run();
    end
endmodule // hppc_top_tb
`default_nettype wire
